// ---- hdl/tpio_pkg.sv ----
package tpio_pkg;

    localparam logic [7:0] TPIO_OFF_PC_PINS  = 8'h00;
    localparam logic [7:0] TPIO_OFF_PC_LATCH = 8'h04;
    localparam logic [7:0] TPIO_OFF_PC_DIR   = 8'h08;
    localparam logic [7:0] TPIO_OFF_PD_PINS  = 8'h0C;
    localparam logic [7:0] TPIO_OFF_PD_LATCH = 8'h10;
    localparam logic [7:0] TPIO_OFF_PD_DIR   = 8'h14;
    localparam logic [7:0] TPIO_OFF_PE_PINS  = 8'h18;
    localparam logic [7:0] TPIO_OFF_PE_LATCH = 8'h1C;
    localparam logic [7:0] TPIO_OFF_PE_DIR   = 8'h20;
    localparam logic [7:0] TPIO_OFF_PE_ANSEL = 8'h24;
    localparam logic [7:0] TPIO_OFF_HP_IRQ   = 8'h28;

    localparam int TPIO_BIT_IBF  = 7;
    localparam int TPIO_BIT_OBF  = 6;
    localparam int TPIO_BIT_IN_OVERFLOW = 5;
    localparam int TPIO_BIT_HPEN = 4;

    localparam logic [7:0] TPIO_RST_DIR   = 8'hFF;
    localparam logic [7:0] TPIO_RST_LATCH = 8'h00;
    localparam logic [7:0] TPIO_RST_PEDIR = 8'h07;
    localparam logic [2:0] TPIO_RST_ANSEL = 3'h7;
    localparam logic [1:0] TPIO_SYNC_STAGES = 2'h2;

    typedef struct packed {
        logic [7:0] spi_data_out;
        logic [7:0] i2c_out;
        logic [7:0] uart_out;
        logic [7:0] en;
    } tpio_pc_periph_t;

    typedef struct packed {
        logic       dual_quad;
        logic       shutdown_tri;
        logic [2:0] en;
        logic [2:0] val;
    } tpio_pwm_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } tpio_pad8_t;

endpackage : tpio_pkg

// ---- hdl/tpio_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // first stage feeds only the second
    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule : tpio_sync
`default_nettype wire

// ---- hdl/tpio_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_top #(
    parameter bit REDUCED_PIN = 1'b0
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [7:0]                 pc_in,
    output tpio_pkg::tpio_pad8_t            pc_pad,
    input  wire tpio_pkg::tpio_pc_periph_t  pc_periph,
    input  wire logic [7:0]                 pd_in,
    output tpio_pkg::tpio_pad8_t            pd_pad,
    output logic                            pd_ttl_levels,
    input  wire tpio_pkg::tpio_pwm_t        pwm,
    input  wire logic [3:0]                 pe_in,
    output logic      [2:0]                 pe_out,
    output logic      [2:0]                 pe_oe,
    input  wire logic                       master_clear_enable,
    output logic                            master_clear_n,
    output logic                            host_port_irq_flag
);
    import tpio_pkg::*;

    logic [7:0] pc_pins, pd_pins;
    logic [3:0] pe_pins;
    logic [7:0] pc_out_latch_reg, pc_out_latch_next;
    logic [7:0] pc_direction_reg, pc_direction_next;
    logic [7:0] pd_out_latch_reg, pd_out_latch_next;
    logic [7:0] pd_direction_reg, pd_direction_next;
    logic [2:0] pe_out_latch_reg, pe_out_latch_next;
    logic [2:0] pe_dir_reg, pe_dir_next;
    logic [2:0] pe_ansel_reg, pe_ansel_next;
    logic       host_port_enable_reg, host_port_enable_next;
    logic       in_buffer_full_reg, in_buffer_full_next;
    logic       out_buffer_full_reg, out_buffer_full_next;
    logic       in_overflow_reg, in_overflow_next;
    logic       irq_reg, irq_next;
    logic       mclr_en_reg, mclr_en_next;
    logic       wr_act_reg, wr_act_next;
    logic       rd_act_reg, rd_act_next;
    logic [7:0] prdata_reg, prdata_next;
    logic       slverr_reg, slverr_next;
    logic       slave_on, wr_low, rd_low, wr_end, rd_end;
    logic       acc, wr, rd, pe_present;
    logic [7:0] pe_dir_view;
    logic       ack_reg, ack_next;

    tpio_sync #(.WIDTH(8)) u_sync_c (
        .clk(clk), .reset_n(reset_n), .d(pc_in), .q(pc_pins)
    );
    tpio_sync #(.WIDTH(8)) u_sync_d (
        .clk(clk), .reset_n(reset_n), .d(pd_in), .q(pd_pins)
    );
    // strobes share these two stages before any edge logic
    tpio_sync #(.WIDTH(4)) u_sync_e (
        .clk(clk), .reset_n(reset_n), .d(pe_in), .q(pe_pins)
    );

    function automatic logic [7:0] ext8(input logic [2:0] v);
        ext8 = {5'h00, v};
    endfunction : ext8

    // error is decided in the first access cycle so it stands with ready
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            TPIO_OFF_PC_PINS,
            TPIO_OFF_PC_LATCH,
            TPIO_OFF_PC_DIR,
            TPIO_OFF_PD_PINS,
            TPIO_OFF_PD_LATCH,
            TPIO_OFF_PD_DIR,
            TPIO_OFF_PE_PINS,
            TPIO_OFF_PE_LATCH,
            TPIO_OFF_PE_DIR,
            TPIO_OFF_PE_ANSEL,
            TPIO_OFF_HP_IRQ:   addr_mapped = 1'b1;
            default:           addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // read data is registered in the first access cycle and stands in the ready cycle
    assign acc        = psel && penable;
    assign wr         = acc && pwrite && ack_reg;
    assign rd         = acc && !pwrite && !ack_reg;
    assign pe_present = !REDUCED_PIN || !mclr_en_reg;

    // dual/quad pwm forces the slave port off
    assign slave_on = host_port_enable_reg && !pwm.dual_quad && !REDUCED_PIN;
    // strobe decode on port E 0..2: read, write, select, all active low
    assign wr_low = slave_on && !pe_pins[2] && !pe_pins[1];
    assign rd_low = slave_on && !pe_pins[2] && !pe_pins[0];
    assign wr_end = wr_act_reg && !wr_low;
    assign rd_end = rd_act_reg && !rd_low;

    // bit 3 reads zero, bits 7..4 slave status and control
    assign pe_dir_view = {in_buffer_full_reg, out_buffer_full_reg, in_overflow_reg,
                          host_port_enable_reg, 1'b0, pe_dir_reg};

    always_comb begin
        pc_out_latch_next     = pc_out_latch_reg;
        pc_direction_next     = pc_direction_reg;
        pd_out_latch_next     = pd_out_latch_reg;
        pd_direction_next     = pd_direction_reg;
        pe_out_latch_next     = pe_out_latch_reg;
        pe_dir_next           = pe_dir_reg;
        pe_ansel_next         = pe_ansel_reg;
        host_port_enable_next = host_port_enable_reg;
        in_buffer_full_next   = in_buffer_full_reg;
        out_buffer_full_next  = out_buffer_full_reg;
        in_overflow_next      = in_overflow_reg;
        irq_next              = irq_reg;
        mclr_en_next          = master_clear_enable; // strap re-sampled every clock, pin 3 role
        wr_act_next           = wr_low;
        rd_act_next           = rd_low;
        prdata_next           = 8'h00;
        slverr_next           = acc && !ack_reg && !addr_mapped(paddr);

        if (wr) begin
            case (paddr)
                TPIO_OFF_PC_PINS, TPIO_OFF_PC_LATCH: pc_out_latch_next = pwdata[7:0];
                TPIO_OFF_PC_DIR:  pc_direction_next = pwdata[7:0];
                TPIO_OFF_PD_PINS, TPIO_OFF_PD_LATCH: begin
                    pd_out_latch_next    = pwdata[7:0];
                    out_buffer_full_next = !rd_low; // read in progress takes it at once
                end
                TPIO_OFF_PD_DIR:  pd_direction_next = pwdata[7:0];
                TPIO_OFF_PE_PINS, TPIO_OFF_PE_LATCH: pe_out_latch_next = pwdata[2:0];
                TPIO_OFF_PE_DIR: begin
                    // buffer-full flags are read-only; overflow only clears
                    pe_dir_next           = pwdata[2:0];
                    host_port_enable_next = pwdata[TPIO_BIT_HPEN];
                    if (!pwdata[TPIO_BIT_IN_OVERFLOW]) in_overflow_next = 1'b0;
                end
                TPIO_OFF_PE_ANSEL: pe_ansel_next = pwdata[2:0];
                TPIO_OFF_HP_IRQ:   if (pwdata[0]) irq_next = 1'b0;
                default:           slverr_next = 1'b1;
            endcase
        end else if (rd) begin
            case (paddr)
                TPIO_OFF_PC_PINS:  prdata_next = pc_pins;
                TPIO_OFF_PC_LATCH: prdata_next = pc_out_latch_reg;
                TPIO_OFF_PC_DIR:   prdata_next = pc_direction_reg;
                TPIO_OFF_PD_PINS: begin
                    // slave mode reads the shared latch holding the external word
                    prdata_next = slave_on ? pd_out_latch_reg : pd_pins;
                    if (slave_on) in_buffer_full_next = 1'b0;
                end
                TPIO_OFF_PD_LATCH: prdata_next = pd_out_latch_reg;
                TPIO_OFF_PD_DIR:   prdata_next = pd_direction_reg;
                // analog pins read as zero; pin 3 only without master clear
                TPIO_OFF_PE_PINS:  prdata_next = {4'h0, !mclr_en_reg && pe_pins[3],
                                      pe_present ? (pe_pins[2:0] & ~pe_ansel_reg) : 3'h0};
                TPIO_OFF_PE_LATCH: prdata_next = ext8(pe_out_latch_reg);
                TPIO_OFF_PE_DIR:   prdata_next = pe_dir_view;
                TPIO_OFF_PE_ANSEL: prdata_next = ext8(pe_ansel_reg);
                TPIO_OFF_HP_IRQ:   prdata_next = {7'h00, irq_reg};
                default:           slverr_next = 1'b1;
            endcase
        end

        // external write end: set wins over cpu clear
        if (wr_end) begin
            if (in_buffer_full_reg) in_overflow_next = 1'b1;
            in_buffer_full_next = 1'b1;
            irq_next            = 1'b1;
        end
        // external read start clears output-full; end raises irq
        if (rd_low && !rd_act_reg) out_buffer_full_next = 1'b0;
        if (rd_end) irq_next = 1'b1;
        if (!slave_on) begin
            wr_act_next = 1'b0;
            rd_act_next = 1'b0;
        end
    end

    // external write captures pins into the latch, direction ignored
    logic [7:0] pd_latch_final;
    assign pd_latch_final = (wr_low && !wr_act_reg) ? pd_latch_next_ext() : pd_out_latch_next;

    function automatic logic [7:0] pd_latch_next_ext();
        pd_latch_next_ext = pd_pins;
    endfunction : pd_latch_next_ext

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_out_latch_reg     <= TPIO_RST_LATCH;
            pc_direction_reg     <= TPIO_RST_DIR;
            pd_out_latch_reg     <= TPIO_RST_LATCH;
            pd_direction_reg     <= TPIO_RST_DIR; // all inputs
            pe_out_latch_reg     <= TPIO_RST_LATCH[2:0];
            pe_dir_reg           <= TPIO_RST_PEDIR[2:0];
            pe_ansel_reg         <= TPIO_RST_ANSEL;
            host_port_enable_reg <= 1'b0;
            in_buffer_full_reg   <= 1'b0;
            out_buffer_full_reg  <= 1'b0;
            in_overflow_reg      <= 1'b0;
            irq_reg              <= 1'b0;
            mclr_en_reg          <= master_clear_enable;
            wr_act_reg           <= 1'b0;
            rd_act_reg           <= 1'b0;
            prdata_reg           <= 8'h00;
            slverr_reg           <= 1'b0;
        end else begin
            pc_out_latch_reg     <= pc_out_latch_next;
            pc_direction_reg     <= pc_direction_next;
            pd_out_latch_reg     <= pd_latch_final;
            pd_direction_reg     <= pd_direction_next;
            pe_out_latch_reg     <= pe_out_latch_next;
            pe_dir_reg           <= pe_dir_next;
            pe_ansel_reg         <= pe_ansel_next;
            host_port_enable_reg <= host_port_enable_next;
            in_buffer_full_reg   <= in_buffer_full_next;
            out_buffer_full_reg  <= out_buffer_full_next;
            in_overflow_reg      <= in_overflow_next;
            irq_reg              <= irq_next;
            mclr_en_reg          <= mclr_en_next;
            wr_act_reg           <= wr_act_next;
            rd_act_reg           <= rd_act_next;
            prdata_reg           <= prdata_next;
            slverr_reg           <= slverr_next;
        end
    end

    // bus handshake: one wait state, so a write lands only at the ready edge
    // and the registered read data is valid while ready is high
    always_comb begin
        ack_next = acc && !ack_reg;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    // port C: serial outputs beat the latch and force the driver on
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pc_pad.o[i]  = pc_periph.en[i] ?
                           (pc_periph.spi_data_out[i] | pc_periph.i2c_out[i]
                            | pc_periph.uart_out[i]) : pc_out_latch_reg[i];
            pc_pad.oe[i] = pc_periph.en[i] || !pc_direction_reg[i];
        end
    end

    // port D: pwm first, then slave read, then direction
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pd_pad.o[i]  = pd_out_latch_reg[i];
            pd_pad.oe[i] = slave_on ? rd_low : !pd_direction_reg[i];
        end
        for (int j = 0; j < 3; j++) begin
            if (pwm.en[j]) begin
                pd_pad.o[j+5]  = pwm.val[j];
                pd_pad.oe[j+5] = !pwm.shutdown_tri;
            end
        end
    end

    assign pd_ttl_levels = slave_on;
    // direction still gates drivers in analog mode; strobes force input
    assign pe_out  = pe_out_latch_reg;
    assign pe_oe   = (pe_present && !slave_on) ? ~pe_dir_reg : 3'h0;
    assign master_clear_n = mclr_en_reg ? pe_pins[3] : 1'b1;
    assign host_port_irq_flag = irq_reg;
    assign prdata  = {24'h00_0000, prdata_reg};
    assign pready  = ack_reg;
    assign pslverr = slverr_reg & ack_reg;
endmodule : tpio_top
`default_nettype wire

// ---- sim/tpio_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_top_asserts
    import tpio_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [7:0]        paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire tpio_pc_periph_t   pc_periph,
    input wire tpio_pad8_t        pc_pad,
    input wire tpio_pad8_t        pd_pad,
    input wire logic              pd_ttl_levels,
    input wire tpio_pwm_t         pwm,
    input wire logic [3:0]        pe_in,
    input wire logic              master_clear_enable,
    input wire logic              master_clear_n,
    input wire logic              host_port_irq_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // strobes must outlast the two-stage synchroniser before anything is judged
    sequence rd_low;
        (pd_ttl_levels && pe_in[2:0] == 3'h2)[*4];
    endsequence
    sequence wr_low;
        (pd_ttl_levels && pe_in[2:0] == 3'h1)[*3];
    endsequence
    // one wait state: ready comes in the second access cycle, never in setup
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not given after one wait state");
    a_ready_setup: assert property (psel && !penable |-> !pready)
        else $error("ready high in setup cycle");
    a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h28 |-> pslverr)
        else $error("no error on unmapped address");
    a_pc_override: assert property (|pc_periph.en |->
        (pc_pad.oe & pc_periph.en) == pc_periph.en && (pc_pad.o & pc_periph.en) ==
        ((pc_periph.spi_data_out | pc_periph.i2c_out | pc_periph.uart_out) & pc_periph.en))
        else $error("serial output not on port c");
    a_pwm_override: assert property (!pwm.shutdown_tri |->
        (pd_pad.oe[7:5] & pwm.en) == pwm.en && (pd_pad.o[7:5] & pwm.en) == (pwm.val & pwm.en))
        else $error("pwm not on port d");
    a_pwm_tristate: assert property (pwm.shutdown_tri |-> (pd_pad.oe[7:5] & pwm.en) == 3'h0)
        else $error("pwm pins driven in shutdown");
    a_dual_quad_off: assert property (pwm.dual_quad |-> !pd_ttl_levels)
        else $error("slave port left on with dual or quad pwm");
    a_host_read: assert property (rd_low |-> pd_pad.oe[4:0] == 5'h1F)
        else $error("latch not driven on external read");
    a_host_idle: assert property ((pd_ttl_levels && pe_in[0])[*4] |-> pd_pad.oe[4:0] == 5'h00)
        else $error("port d driven without external read");
    a_write_irq: assert property (wr_low ##1 pe_in[1] |-> ##[0:4] host_port_irq_flag)
        else $error("write end did not raise flag");
    a_pin3_port: assert property (!master_clear_enable |-> master_clear_n)
        else $error("master clear active while disabled");
    a_pin3_clear: assert property ((master_clear_enable && !pe_in[3])[*4] |-> !master_clear_n)
        else $error("master clear not following pin");
endmodule : tpio_top_asserts
bind tpio_top tpio_top_asserts u_chk (.*);
`default_nettype wire

// ---- sim/tpio_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_host_model
    import tpio_pkg::*;
(
    input  wire logic       clk,
    input  wire tpio_pad8_t pd_pad,
    output logic      [7:0] pd_in,
    output logic      [2:0] strobe_n
);
    logic [7:0] drv;
    logic       drv_en;
    initial begin
        drv = 8'h33;
        drv_en = 1'b1;
        strobe_n = 3'h7;
    end
    // a released bus shows the inverse, so a stale copy can never pass
    assign pd_in = (pd_pad.oe & pd_pad.o) | (~pd_pad.oe & (drv_en ? drv : ~drv));
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        drv <= d;
        drv_en <= 1'b1;
        strobe_n <= 3'h1;
        repeat (4) @(posedge clk);
        strobe_n <= 3'h7;
        repeat (4) @(posedge clk);
        drv_en <= 1'b0;
    endtask : wr
    task automatic rd(output logic [7:0] d);
        @(posedge clk);
        drv_en <= 1'b0;
        strobe_n <= 3'h2;
        repeat (5) @(posedge clk);
        d = pd_in;
        strobe_n <= 3'h7;
        repeat (4) @(posedge clk);
    endtask : rd
endmodule : tpio_host_model
`default_nettype wire

// ---- sim/tpio_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_top_tb_top;
    import tpio_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, errv, ttl, mce, mclr_n, irq, pe3;
    logic [7:0] paddr, pc_in, pd_in, rdv, d;
    logic [31:0] pwdata, prdata;
    logic [2:0] pe_out, pe_oe, strobe_n;
    tpio_pad8_t pc_pad, pd_pad;
    tpio_pc_periph_t pc_periph;
    tpio_pwm_t pwm;
    int miscompares = 0;
    int n_tests = 0;
    assign pc_in = (pc_pad.oe & pc_pad.o) | (~pc_pad.oe & 8'h3C);
    tpio_top i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc_in(pc_in), .pc_pad(pc_pad), .pc_periph(pc_periph),
        .pd_in(pd_in), .pd_pad(pd_pad), .pd_ttl_levels(ttl), .pwm(pwm),
        .pe_in({pe3, (pe_oe & pe_out) | (~pe_oe & strobe_n)}), .pe_out(pe_out), .pe_oe(pe_oe),
        .master_clear_enable(mce), .master_clear_n(mclr_n), .host_port_irq_flag(irq));
    tpio_host_model m (.clk(clk), .pd_pad(pd_pad), .pd_in(pd_in), .strobe_n(strobe_n));
    always #25 clk = ~clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata[7:0];
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdv, e);
    endtask : rc
    task automatic t_port_d;
        rc(TPIO_OFF_PD_DIR, 8'hFF);
        rc(TPIO_OFF_PE_DIR, 8'h07);
        chk(pd_pad.oe, 8'h00);
        apb(1'b1, TPIO_OFF_PD_LATCH, 8'hA5);
        apb(1'b1, TPIO_OFF_PD_DIR, 8'h0F);
        chk(pd_pad.oe & pd_pad.o, 8'hA0);
        chk(pd_pad.oe, 8'hF0);
        rc(TPIO_OFF_PD_LATCH, 8'hA5);
        rc(TPIO_OFF_PD_PINS, 8'hA3);
        apb(1'b1, TPIO_OFF_PD_DIR, 8'hFF);
    endtask : t_port_d
    task automatic t_port_ce;
        apb(1'b1, TPIO_OFF_PC_DIR, 8'hDF);
        pc_periph <= {8'h20, 8'h00, 8'h40, 8'h60};
        repeat (2) @(posedge clk);
        chk(pc_pad.oe & pc_pad.o, 8'h60);
        pc_periph <= '0;
        rc(TPIO_OFF_PC_DIR, 8'hDF);
        rc(TPIO_OFF_PE_PINS, 8'h08);
        apb(1'b1, TPIO_OFF_PE_DIR, 8'h00);
        chk({5'h00, pe_oe}, 8'h07);
        apb(1'b1, TPIO_OFF_PE_DIR, 8'h07);
        apb(1'b1, TPIO_OFF_PE_ANSEL, 8'h00);
        rc(TPIO_OFF_PE_PINS, 8'h0F);
        mce <= 1'b1;
        pe3 <= 1'b0;
        repeat (5) @(posedge clk);
        chk({7'h00, mclr_n}, 8'h00);
        pe3 <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, mclr_n}, 8'h01);
        mce <= 1'b0;
    endtask : t_port_ce
    task automatic t_host;
        apb(1'b1, TPIO_OFF_PE_DIR, 8'h17);
        chk({7'h00, ttl}, 8'h01);
        apb(1'b1, TPIO_OFF_PD_LATCH, 8'h5A);
        m.rd(d);
        chk(d, 8'h5A);
        rc(TPIO_OFF_PE_DIR, 8'h17);
        m.wr(8'h3C);
        rc(TPIO_OFF_PE_DIR, 8'h97);
        chk({7'h00, irq}, 8'h01);
        m.wr(8'hC3);
        rc(TPIO_OFF_PE_DIR, 8'hB7);
        rc(TPIO_OFF_PD_PINS, 8'hC3);
        rc(TPIO_OFF_PE_DIR, 8'h37);
        apb(1'b1, TPIO_OFF_PE_DIR, 8'hD7);
        rc(TPIO_OFF_PE_DIR, 8'h17);
        apb(1'b1, TPIO_OFF_HP_IRQ, 8'h01);
        rc(TPIO_OFF_HP_IRQ, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        chk({7'h00, errv}, 8'h01);
    endtask : t_host
    task automatic t_pwm;
        pwm <= {1'b1, 1'b0, 3'h0, 3'h0};
        repeat (2) @(posedge clk);
        chk({7'h00, ttl}, 8'h00);
        m.wr(8'h77);
        rc(TPIO_OFF_PE_DIR, 8'h17);
        pwm <= {1'b0, 1'b0, 3'h7, 3'h5};
        repeat (2) @(posedge clk);
        chk({2'h0, pd_pad.o[7:5], pd_pad.oe[7:5]}, 8'h2F);
        pwm <= {1'b0, 1'b1, 3'h7, 3'h5};
        repeat (2) @(posedge clk);
        chk({5'h00, pd_pad.oe[7:5]}, 8'h00);
        pwm <= '0;
    endtask : t_pwm
    task automatic wrap_up;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        {reset_n, psel, penable, pwrite, mce, pe3} = 6'h01;
        {paddr, pwdata} = '0;
        pc_periph = '0;
        pwm = '0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_port_d();
        t_port_ce();
        t_host();
        t_pwm();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : tpio_top_tb_top
`default_nettype wire
